//--- pkg/dac_consts.svh
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

// ==========================================================
// Frame geometry
`define DAC_FRAME_BITS      6'h20
`define DAC_LAST_BIT        6'h1F
`define DAC_CMD_MSB         27
`define DAC_CMD_LSB         24
`define DAC_ADDR_MSB        23
`define DAC_ADDR_LSB        20
`define DAC_DATA_MSB        19
`define DAC_DATA_LSB        4
`define DAC_PD_MODE_MSB     9
`define DAC_PD_MODE_LSB     8

// ==========================================================
// Channel addresses
`define DAC_ADDR_A          4'h0
`define DAC_ADDR_B          4'h1
`define DAC_ADDR_ALL        4'hF

// ==========================================================
// Output codes
`define DAC_CODE_ZERO       16'h0000
`define DAC_CODE_MID        16'h8000
`define DAC_CODE_FULL       16'hFFFF

// ==========================================================
// Clear code settings
`define DAC_CLR_ZERO        2'h0
`define DAC_CLR_MID         2'h1
`define DAC_CLR_FULL        2'h2

// ==========================================================
// Pin filter and power-up settling
`define DAC_PIN_COUNT       7
`define DAC_PIN_RESET       7'h7F
`define DAC_POR_SETTLE      3'h5

// ==========================================================
// Register byte offsets
`define DAC_REG_STATUS      8'h00
`define DAC_REG_OUT_A       8'h04
`define DAC_REG_OUT_B       8'h08
`define DAC_REG_IN_A        8'h0C
`define DAC_REG_IN_B        8'h10
`define DAC_REG_CONFIG      8'h14
`define DAC_CFG_UPDATE_BIT  2

`endif

//--- pkg/dac_pkg.sv
`default_nettype none

package dac_pkg;

  // ========================================================
  // Serial commands carried in a frame
  typedef enum logic [3:0] {
    CMD_WRITE_IN  = 4'h0,
    CMD_UPDATE    = 4'h1,
    CMD_WRITE_UPD = 4'h3,
    CMD_POWERDOWN = 4'h4,
    CMD_CLEAR_SET = 4'h5
  } cmd_type;

  // ========================================================
  // Frame receiver states
  typedef enum logic [2:0] {
    FRAME_IDLE  = 3'b001,
    FRAME_SHIFT = 3'b010,
    FRAME_WAIT  = 3'b100
  } frame_state_type;

  // ========================================================
  // Filtered pin group, high bit first
  typedef struct packed {
    logic por_mid;
    logic lockout_n;
    logic clear_n;
    logic load_n;
    logic din;
    logic frame_sel_n;
    logic sclk;
  } pin_bits_type;

  // ========================================================
  // One channel as seen by the analog side
  typedef struct packed {
    logic        powered_down;
    logic [15:0] code;
  } chan_out_type;

endpackage : dac_pkg

`default_nettype wire

//--- rtl/dual_dac_serial_control.sv
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`include "dac_consts.svh"
`default_nettype none

module dual_dac_serial_control (
  input  wire logic                 clk_sys,             // 25 MHz clock
  input  wire logic                 reset,               // Sync, high
  input  wire logic                 sclk,                // Serial clock
  input  wire logic                 frame_sel_n,         // Frame select
  input  wire logic                 din,                 // Serial data in
  input  wire logic                 load_output_strobe_n,// Load strobe
  input  wire logic                 async_clear_n,       // Clear input
  input  wire logic                 powerdown_lockout_n, // Lockout pin
  input  wire logic                 power_up_mid,        // Power-up select
  output logic                      serial_out,          // Serial out
  output dac_pkg::chan_out_type     chan_a,              // Channel A
  output dac_pkg::chan_out_type     chan_b,              // Channel B
  input  wire logic [7:0]           avs_address,         // Byte address
  input  wire logic                 avs_read,            // Read request
  input  wire logic                 avs_write,           // Write request
  input  wire logic [3:0]           avs_byteenable,      // Byte lanes
  input  wire logic [31:0]          avs_writedata,       // Write data
  output logic [31:0]               avs_readdata,        // Read data
  output logic                      avs_waitrequest      // Stall
);

  // ========================================================
  // Pin filtering
  dac_pkg::pin_bits_type pin_f;
  dac_pkg::pin_bits_type pin_q;
  pin_filter u_pin_filter (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pins    ({power_up_mid, powerdown_lockout_n, async_clear_n,
               load_output_strobe_n, din, frame_sel_n, sclk}),
    .filt    (pin_f)
  );

  // Previous filtered levels for edge finding
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_q <= `DAC_PIN_RESET;
    end else begin
      pin_q <= pin_f;
    end
  end

  logic sclk_fall;
  logic sclk_rise;
  logic fs_fall;
  logic fs_rise;
  logic clr_fall;
  logic lock_fall;
  assign sclk_fall = pin_q.sclk & ~pin_f.sclk;
  assign sclk_rise = ~pin_q.sclk & pin_f.sclk;
  assign fs_fall   = pin_q.frame_sel_n & ~pin_f.frame_sel_n;
  assign fs_rise   = ~pin_q.frame_sel_n & pin_f.frame_sel_n;
  assign clr_fall  = pin_q.clear_n & ~pin_f.clear_n;
  assign lock_fall = pin_q.lockout_n & ~pin_f.lockout_n;

  // ========================================================
  // Power-up settling: filters fill before the strap is read
  logic [2:0] por_cnt;
  logic       por_done;
  logic       por_load;
  assign por_load = ~por_done & (por_cnt == `DAC_POR_SETTLE);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      por_cnt  <= 3'h0;
      por_done <= 1'b0;
    end else if (!por_done) begin
      por_cnt  <= por_cnt + 3'h1;
      por_done <= por_load;
    end
  end

  // ========================================================
  // Frame receiver
  dac_pkg::frame_state_type state;
  logic [5:0]  bit_cnt;
  logic [31:0] shift;
  logic        frame_done;

  // Abort wins over a falling clock seen in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state      <= dac_pkg::FRAME_IDLE;
      bit_cnt    <= 6'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      unique case (state)
        dac_pkg::FRAME_IDLE: begin
          if (fs_fall) begin
            state   <= dac_pkg::FRAME_SHIFT;
            bit_cnt <= 6'h00;
          end
        end
        dac_pkg::FRAME_SHIFT: begin
          if (fs_rise) begin
            state <= dac_pkg::FRAME_IDLE;
          end else if (sclk_fall) begin
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt == `DAC_LAST_BIT) begin
              state      <= dac_pkg::FRAME_WAIT;
              frame_done <= 1'b1;
            end
          end
        end
        dac_pkg::FRAME_WAIT: begin
          // Extra clocks after the 32nd are ignored
          if (fs_rise) begin
            state <= dac_pkg::FRAME_IDLE;
          end
        end
        default: begin
          state <= dac_pkg::FRAME_IDLE;
        end
      endcase
    end
  end

  // Shift register keeps last word for readback
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shift <= 32'h0000_0000;
    end else if (state == dac_pkg::FRAME_SHIFT && sclk_fall
                 && !fs_rise) begin
      shift <= {shift[30:0], pin_f.din};
    end
  end

  // Serial out: old word leaves MSB first, MSB at frame select fall, rest on rising clock
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serial_out <= 1'b0;
    end else if (fs_fall || sclk_rise) begin
      serial_out <= shift[31];
    end
  end

  // ========================================================
  // Frame decode
  dac_pkg::cmd_type cmd;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic [1:0]  sel;
  assign cmd   = dac_pkg::cmd_type'(shift[`DAC_CMD_MSB:`DAC_CMD_LSB]);
  assign addr  = shift[`DAC_ADDR_MSB:`DAC_ADDR_LSB];
  assign wdata = shift[`DAC_DATA_MSB:`DAC_DATA_LSB];
  assign sel   = {addr == `DAC_ADDR_B || addr == `DAC_ADDR_ALL,
                  addr == `DAC_ADDR_A || addr == `DAC_ADDR_ALL};

  logic wr_in;
  logic wr_upd;
  logic pd_cmd;
  logic clr_set;
  assign wr_in   = frame_done & por_done
                   & (cmd == dac_pkg::CMD_WRITE_IN
                      || cmd == dac_pkg::CMD_WRITE_UPD);
  assign wr_upd  = frame_done & por_done
                   & (cmd == dac_pkg::CMD_UPDATE
                      || cmd == dac_pkg::CMD_WRITE_UPD);
  assign pd_cmd  = frame_done & (cmd == dac_pkg::CMD_POWERDOWN);
  assign clr_set = frame_done & (cmd == dac_pkg::CMD_CLEAR_SET);

  // ========================================================
  // Clear code setting, by frame or by bus
  logic [1:0]  clear_code;
  logic [15:0] clear_value;
  logic        cfg_wr;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clear_code <= `DAC_CLR_ZERO;
    end else if (clr_set) begin
      clear_code <= shift[1:0];
    end else if (cfg_wr && avs_byteenable[0]) begin
      clear_code <= avs_writedata[1:0];
    end
  end
  always_comb begin
    unique case (clear_code)
      `DAC_CLR_MID:  clear_value = `DAC_CODE_MID;
      `DAC_CLR_FULL: clear_value = `DAC_CODE_FULL;
      default:       clear_value = `DAC_CODE_ZERO;
    endcase
  end

  // ========================================================
  // Input and output registers
  logic [15:0] in_a;
  logic [15:0] in_b;
  logic        load_now;
  logic        sw_update;
  // Level-sensitive load covers both pulsed and tied-low use
  assign load_now = por_done & ~pin_f.load_n & pin_f.clear_n;

  // Clear beats any write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_a <= `DAC_CODE_ZERO;
      in_b <= `DAC_CODE_ZERO;
    end else if (por_load) begin
      in_a <= pin_f.por_mid ? `DAC_CODE_MID : `DAC_CODE_ZERO;
      in_b <= pin_f.por_mid ? `DAC_CODE_MID : `DAC_CODE_ZERO;
    end else if (por_done && clr_fall) begin
      in_a <= clear_value;
      in_b <= clear_value;
    end else if (wr_in) begin
      if (sel[0]) in_a <= wdata;
      if (sel[1]) in_b <= wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chan_a.code <= `DAC_CODE_ZERO;
      chan_b.code <= `DAC_CODE_ZERO;
    end else if (por_load) begin
      chan_a.code <= pin_f.por_mid ? `DAC_CODE_MID : `DAC_CODE_ZERO;
      chan_b.code <= pin_f.por_mid ? `DAC_CODE_MID : `DAC_CODE_ZERO;
    end else if (por_done && clr_fall) begin
      chan_a.code <= clear_value;
      chan_b.code <= clear_value;
    end else if (load_now || sw_update) begin
      chan_a.code <= in_a;
      chan_b.code <= in_b;
    end else if (wr_upd) begin
      if (sel[0]) chan_a.code <= wr_in ? wdata : in_a;
      if (sel[1]) chan_b.code <= wr_in ? wdata : in_b;
    end
  end

  // ========================================================
  // Software power-down and lockout
  logic [1:0] pd_mode;
  assign pd_mode = shift[`DAC_PD_MODE_MSB:`DAC_PD_MODE_LSB];
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chan_a.powered_down <= 1'b0;
      chan_b.powered_down <= 1'b0;
    end else if (lock_fall) begin
      chan_a.powered_down <= 1'b0;
      chan_b.powered_down <= 1'b0;
    end else if (pd_cmd && (pin_f.lockout_n || pd_mode == 2'h0)) begin
      if (shift[0]) chan_a.powered_down <= (pd_mode != 2'h0);
      if (shift[1]) chan_b.powered_down <= (pd_mode != 2'h0);
    end
  end

  // ========================================================
  // Avalon-MM slave: one wait cycle, answer on the second edge
  logic ack;
  logic req;
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign cfg_wr          = avs_write & ack
                           & (avs_address == `DAC_REG_CONFIG);
  assign sw_update       = cfg_wr & avs_byteenable[0]
                           & avs_writedata[`DAC_CFG_UPDATE_BIT]
                           & pin_f.clear_n & por_done;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      unique case (avs_address)
        `DAC_REG_STATUS: avs_readdata <= {24'h00_0000,
            state == dac_pkg::FRAME_SHIFT, pin_f.load_n,
            pin_f.lockout_n, pin_f.clear_n, por_done,
            ~pin_f.frame_sel_n, chan_b.powered_down,
            chan_a.powered_down};
        `DAC_REG_OUT_A:  avs_readdata <= {16'h0000, chan_a.code};
        `DAC_REG_OUT_B:  avs_readdata <= {16'h0000, chan_b.code};
        `DAC_REG_IN_A:   avs_readdata <= {16'h0000, in_a};
        `DAC_REG_IN_B:   avs_readdata <= {16'h0000, in_b};
        `DAC_REG_CONFIG: avs_readdata <= {30'h0000_0000, clear_code};
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================
  // Checks
  property p_load_transfer;
    @(posedge clk_sys) disable iff (reset)
    (load_now && !clr_fall) |=> (chan_a.code == $past(in_a)
                                 && chan_b.code == $past(in_b));
  endproperty
  a_load_transfer: assert property (p_load_transfer)
    else $error("load strobe did not move input to output");

  property p_frame_open;
    @(posedge clk_sys) disable iff (reset)
    (state == dac_pkg::FRAME_IDLE && fs_fall)
      |=> (state == dac_pkg::FRAME_SHIFT && bit_cnt == 6'h00);
  endproperty
  a_frame_open: assert property (p_frame_open)
    else $error("frame select fall did not open a frame");

  property p_bit_count;
    @(posedge clk_sys) disable iff (reset)
    (state == dac_pkg::FRAME_SHIFT && sclk_fall && !fs_rise)
      |=> bit_cnt == $past(bit_cnt) + 6'h01;
  endproperty
  a_bit_count: assert property (p_bit_count)
    else $error("falling clock not counted");

  property p_abort;
    @(posedge clk_sys) disable iff (reset)
    (state == dac_pkg::FRAME_SHIFT && fs_rise)
      |=> (state == dac_pkg::FRAME_IDLE && !frame_done) ##1 !frame_done;
  endproperty
  a_abort: assert property (p_abort)
    else $error("aborted frame was executed");

  property p_shift_in;
    @(posedge clk_sys) disable iff (reset)
    (state == dac_pkg::FRAME_SHIFT && sclk_fall && !fs_rise)
      |=> (shift[0] == $past(pin_f.din)
           && shift[31:1] == $past(shift[30:0]));
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("shift register did not take data bit");

  property p_sdo_launch;
    @(posedge clk_sys) disable iff (reset)
    sclk_rise |=> serial_out == $past(shift[31]);
  endproperty
  a_sdo_launch: assert property (p_sdo_launch)
    else $error("serial out not launched on rising clock");

  property p_por_level;
    @(posedge clk_sys) disable iff (reset)
    por_load |=> (chan_a.code == ($past(pin_f.por_mid) ? `DAC_CODE_MID
                                  : `DAC_CODE_ZERO)
                  && chan_b.code == chan_a.code);
  endproperty
  a_por_level: assert property (p_por_level)
    else $error("power-up level wrong");

  property p_clear_hold;
    @(posedge clk_sys) disable iff (reset)
    (por_done && !pin_f.clear_n && !clr_fall && !wr_upd)
      |=> $stable(chan_a.code) && $stable(chan_b.code);
  endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("output changed by load while clear low");

  property p_clear_load;
    @(posedge clk_sys) disable iff (reset)
    (por_done && clr_fall) |=> (chan_a.code == $past(clear_value)
                                && in_b == $past(clear_value));
  endproperty
  a_clear_load: assert property (p_clear_load)
    else $error("clear did not load clear code");

  property p_lock_refuse;
    @(posedge clk_sys) disable iff (reset)
    (!pin_f.lockout_n && !chan_a.powered_down) |=> !chan_a.powered_down;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("power-down entered under lockout");

  property p_lock_wake;
    @(posedge clk_sys) disable iff (reset)
    lock_fall |=> (!chan_a.powered_down && !chan_b.powered_down
                   && $stable(chan_a.code));
  endproperty
  a_lock_wake: assert property (p_lock_wake)
    else $error("lockout fall did not wake channels");

  c_full_frame: cover property (@(posedge clk_sys) disable iff (reset)
    frame_done);
  c_abort: cover property (@(posedge clk_sys) disable iff (reset)
    state == dac_pkg::FRAME_SHIFT && fs_rise);
  c_clear: cover property (@(posedge clk_sys) disable iff (reset)
    por_done && clr_fall);
  c_wake: cover property (@(posedge clk_sys) disable iff (reset)
    lock_fall && chan_a.powered_down);

endmodule : dual_dac_serial_control

`default_nettype wire

//--- rtl/pin_filter.sv
`include "dac_consts.svh"
`default_nettype none

module pin_filter (
  input  wire logic                        clk_sys, // System clock
  input  wire logic                        reset,   // Sync reset, high
  input  wire logic [`DAC_PIN_COUNT-1:0]   pins,    // Raw pin levels
  output logic      [`DAC_PIN_COUNT-1:0]   filt     // Filtered levels
);

  // ========================================================
  // Three-stage sampler per pin
  // Idle reset level is high: all active-low pins at rest
  localparam logic [`DAC_PIN_COUNT-1:0] pin_idle = `DAC_PIN_RESET;
  genvar i;
  generate
    for (i = 0; i < `DAC_PIN_COUNT; i = i + 1) begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      // First stage feeds only the second one
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          s1 <= pin_idle[i];
          s2 <= pin_idle[i];
          s3 <= pin_idle[i];
        end else begin
          s1 <= pins[i];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // Level accepted once two later stages agree
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          filt[i] <= pin_idle[i];
        end else if (s2 == s3) begin
          filt[i] <= s3;
        end
      end
    end
  endgenerate

endmodule : pin_filter

`default_nettype wire

//--- verification/host_link_model.sv
`default_nettype none

module host_link_model (
  input  wire logic clk_sys,     // System clock
  input  wire logic serial_out,  // Chained data back from the device
  output var logic  sclk,        // Serial clock, stands high idle
  output var logic  frame_sel_n, // Frame select
  output var logic  din          // Serial data
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================
  // Idle levels; clock stands still outside frames
  initial begin
    sclk        = 1'b1;
    frame_sel_n = 1'b1;
    din         = 1'b0;
  end

  // Half period of four system cycles, 320 ns clock
  task automatic half;
    repeat (4) @(posedge clk_sys);
  endtask : half

  // Frame of nfall falls, MSB first; data moves on the rise
  // so it is steady for a whole half period around each fall
  task automatic send(input logic [31:0] word, input int nfall,
                      output logic [31:0] seen);
    seen = 32'h0000_0000;
    frame_sel_n <= 1'b0;
    din         <= word[31];
    half();
    for (int i = 0; i < nfall; i++) begin
      sclk <= 1'b0;
      half();
      seen = {seen[30:0], serial_out};
      sclk <= 1'b1;
      if (i < 31) din <= word[30-i];
      half();
    end
    frame_sel_n <= 1'b1;
    din         <= ~word[32-nfall]; // Released line shows no stale bit
    repeat (12) @(posedge clk_sys);
  endtask : send
endmodule : host_link_model

`default_nettype wire

//--- verification/tb_dual_dac_serial_control.sv
`include "dac_consts.svh"
`default_nettype none

module tb_dual_dac_serial_control;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  clk_sys = 1'b0;
  logic                  reset = 1'b1;
  logic                  sclk, frame_sel_n, din, serial_out;
  logic                  load_output_strobe_n = 1'b1;
  logic                  async_clear_n = 1'b1;
  logic                  powerdown_lockout_n = 1'b1;
  logic                  power_up_mid = 1'b1;
  dac_pkg::chan_out_type chan_a, chan_b;
  logic [7:0]            avs_address = 8'h00;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = 32'h0000_0000;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  int                    errors = 0;
  int                    tests_run = 0;
  int                    cycles = 0;

  // ==========================================
  // Clock and units
  always #20 clk_sys = ~clk_sys;

  dual_dac_serial_control dual_dac_serial_control_i (
    .clk_sys, .reset, .sclk, .frame_sel_n, .din, .load_output_strobe_n,
    .async_clear_n, .powerdown_lockout_n, .power_up_mid, .serial_out,
    .chan_a, .chan_b, .avs_address, .avs_read, .avs_write,
    .avs_byteenable(4'hF), .avs_writedata, .avs_readdata,
    .avs_waitrequest);

  host_link_model host_link_model_i (
    .clk_sys, .serial_out, .sclk, .frame_sel_n, .din);

  // ==========================================
  // Helpers
  function automatic logic [31:0] frame(input logic [3:0] cmd, adr,
                                        input logic [15:0] d,
                                        input logic [3:0] lo);
    return {4'h0, cmd, adr, d, lo};
  endfunction : frame

  task automatic wrap_up;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string name, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] adr,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_address   <= adr;
    avs_writedata <= wd;
    // Only the hang guard ends a wait that never answers
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input string name, input logic [7:0] adr,
                       input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, adr, 32'h0000_0000, v);
    check(name, v, exp);
  endtask : rdchk

  // Short low pulse, then back high as chained use needs
  task automatic pulse_load;
    load_output_strobe_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    load_output_strobe_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : pulse_load

  task automatic do_reset(input logic strap);
    reset        <= 1'b1;
    power_up_mid <= strap;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (20) @(posedge clk_sys);
  endtask : do_reset

  // ==========================================
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] v, w1;
    logic [15:0] da, db, x;
    logic [15:0] code_tab [3];
    code_tab = '{16'h0000, 16'h8000, 16'hFFFF};
    void'($urandom(32'h1075));
    da = 16'($urandom());
    db = 16'($urandom());
    do_reset(1'b1);
    check("pu_a", {16'h0, chan_a.code}, 32'h0000_8000);
    check("pu_b", {16'h0, chan_b.code}, 32'h0000_8000);
    w1 = frame(4'h0, `DAC_ADDR_A, da, 4'h0);
    host_link_model_i.send(w1, 32, v);
    host_link_model_i.send(frame(4'h0, `DAC_ADDR_B, db, 4'h0), 32, v);
    check("readback", v, w1);
    rdchk("in_a", `DAC_REG_IN_A, {16'h0, da});
    check("held_a", {16'h0, chan_a.code}, 32'h0000_8000);
    host_link_model_i.send(frame(4'h0, `DAC_ADDR_A, ~da, 4'h0), 31, v);
    rdchk("abort", `DAC_REG_IN_A, {16'h0, da});
    pulse_load();
    check("ld_a", {16'h0, chan_a.code}, {16'h0, da});
    check("ld_b", {16'h0, chan_b.code}, {16'h0, db});
    // Strobe tied low: output follows input
    x = 16'($urandom());
    load_output_strobe_n <= 1'b0;
    host_link_model_i.send(frame(4'h0, `DAC_ADDR_B, x, 4'h0), 32, v);
    check("follow_b", {16'h0, chan_b.code}, {16'h0, x});
    load_output_strobe_n <= 1'b1;
    // Random write-and-update to either channel
    for (int i = 0; i < 4; i++) begin
      x = 16'($urandom());
      host_link_model_i.send(frame(4'h3, 4'(i % 2), x, 4'h0), 32, v);
      v = {16'h0000, (i % 2) ? chan_b.code : chan_a.code};
      check("wr_upd", v, {16'h0, x});
    end
    // Command update, then software update over the bus
    x = 16'($urandom());
    host_link_model_i.send(frame(4'h0, `DAC_ADDR_A, x, 4'h0), 32, v);
    host_link_model_i.send(frame(4'h1, `DAC_ADDR_A, 16'h0, 4'h0), 32, v);
    check("cmd_upd", {16'h0, chan_a.code}, {16'h0, x});
    x = 16'($urandom());
    host_link_model_i.send(frame(4'h0, `DAC_ADDR_B, x, 4'h0), 32, v);
    bus(1'b1, `DAC_REG_CONFIG, 32'h0000_0004, v);
    // Output lands at the accepting edge; look two edges later
    repeat (2) @(posedge clk_sys);
    check("sw_upd", {16'h0, chan_b.code}, {16'h0, x});
    // Clear codes: default, then serial set, then register set
    for (int k = 0; k < 3; k++) begin
      if (k == 1)
        host_link_model_i.send(frame(4'h5, 4'h0, 16'h0, 4'h1), 32, v);
      if (k == 2) bus(1'b1, `DAC_REG_CONFIG, 32'h0000_0002, v);
      async_clear_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      check("clr_a", {16'h0, chan_a.code}, {16'h0, code_tab[k]});
      check("clr_b", {16'h0, chan_b.code}, {16'h0, code_tab[k]});
      rdchk("clr_in", `DAC_REG_IN_B, {16'h0, code_tab[k]});
      host_link_model_i.send(frame(4'h0, `DAC_ADDR_A, da, 4'h0), 32, v);
      pulse_load();
      check("clr_ld", {16'h0, chan_a.code}, {16'h0, code_tab[k]});
      async_clear_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
    end
    rdchk("cfg", `DAC_REG_CONFIG, 32'h0000_0002);
    rdchk("unmapped", 8'h40, 32'h0000_0000);
    // Power-down with lockout high, wake by lockout fall
    host_link_model_i.send(frame(4'h4, 4'h0, 16'h0010, 4'h3), 32, v);
    check("pd_a", {31'h0, chan_a.powered_down}, 32'h0000_0001);
    check("pd_b", {31'h0, chan_b.powered_down}, 32'h0000_0001);
    rdchk("status", `DAC_REG_STATUS, 32'h0000_007B);
    powerdown_lockout_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check("wake", {15'h0, chan_a}, 32'h0000_FFFF);
    host_link_model_i.send(frame(4'h4, 4'h0, 16'h0010, 4'h3), 32, v);
    check("locked", {31'h0, chan_b.powered_down}, 32'h0);
    powerdown_lockout_n <= 1'b1;
    do_reset(1'b0);
    check("pu_zero", {16'h0, chan_a.code}, 32'h0000_0000);
    wrap_up();
  end
endmodule : tb_dual_dac_serial_control

`default_nettype wire
